// >>> hw/cip_consts.svh
/*
 * Constants of the camera isochronous packetizer: format/mode codes, rate
 * codes, frame sizes, payload bases and the layout of a buffered byte word.
 * Assumes it is included by bare name from design files only.
 */
`ifndef CIP_CONSTS_SVH
`define CIP_CONSTS_SVH

// Format/mode pairs, written as {format[1:0], mode[2:0]}
`define CIP_F0M1 5'h01
`define CIP_F0M5 5'h05
`define CIP_F0M6 5'h06
`define CIP_F1M2 5'h0a
`define CIP_F1M5 5'h0d
`define CIP_F1M6 5'h0e
`define CIP_F1M7 5'h0f
`define CIP_F2M2 5'h12
`define CIP_F2M6 5'h16

// Frame rate codes, slowest first; each step doubles the payload
`define CIP_R1P875 3'h0
`define CIP_R3P75  3'h1
`define CIP_R7P5   3'h2
`define CIP_R15    3'h3
`define CIP_R30    3'h4
`define CIP_R60    3'h5

// Frame sizes in pixels and rows
`define CIP_W320  11'h140
`define CIP_H240  11'h0f0
`define CIP_W640  11'h280
`define CIP_H480  11'h1e0
`define CIP_W800  11'h320
`define CIP_H600  11'h258
`define CIP_W1024 11'h400
`define CIP_H768  11'h300
`define CIP_W1280 11'h500
`define CIP_H960  11'h3c0

// Payload bytes per packet at rate code 0; real size is base << rate
`define CIP_B_F0M1 13'h028
`define CIP_B_F0M5 13'h050
`define CIP_B_F0M6 13'h0a0
`define CIP_B_F1M2 13'h07d
`define CIP_B_F1M5 13'h0c0
`define CIP_B_F1M6 13'h0fa
`define CIP_B_F1M7 13'h180
`define CIP_B_F2M2 13'h140
`define CIP_B_F2M6 13'h280

// Buffered word: {sync, sop, eop, data[7:0]}
`define CIP_BW      11
`define CIP_BIT_SYN 10
`define CIP_BIT_SOP 9
`define CIP_BIT_EOP 8

`endif

// >>> hw/cip_pkg.sv
/*
 * Types of the camera isochronous packetizer.
 * Assumes nothing of its surroundings.
 */
package cip_pkg;

	// Pixel coding of the selected format
	typedef enum logic [1:0] {
		CIP_PIX_M8  = 2'b00,
		CIP_PIX_M16 = 2'b01,
		CIP_PIX_YUV = 2'b10
	} cip_pix_t;

	// Byte serializer states
	typedef enum logic [1:0] {
		CIP_S_IDLE = 2'b00,
		CIP_S_LO   = 2'b01,
		CIP_S_HI   = 2'b10
	} cip_state_t;

	// Decoded format/mode/rate selection
	typedef struct packed {
		logic        valid;
		cip_pix_t    pix;
		logic [10:0] width;
		logic [10:0] height;
		logic [12:0] size;
	} cip_fmt_t;

endpackage : cip_pkg

// >>> hw/cip_skid2.sv
/*
 * Two-entry buffer between the byte serializer and the packet output.
 * Assumes one clock; the drain side may hold ready low for any time.
 */
`timescale 1ns/1ps
`default_nettype none

module cip_skid2 #(
	parameter int WIDTH = 8
) (
	input  wire logic             ref_clk,
	input  wire logic             resetn,
	input  wire logic             in_valid,
	output var  logic             in_ready_r,
	input  wire logic [WIDTH-1:0] in_data,
	output var  logic             out_valid_r,
	input  wire logic             out_ready,
	output var  logic [WIDTH-1:0] out_data_r
);

	logic             skid_valid_r;
	logic [WIDTH-1:0] skid_data_r;
	logic             out_valid_nxt;
	logic             skid_valid_nxt;
	logic [WIDTH-1:0] out_data_nxt;
	logic [WIDTH-1:0] skid_data_nxt;
	logic             push;
	logic             pop;

	////////////////////////////////////////////////////////////////////
	// Output register refills from the skid slot first, keeping order
	always_comb begin
		push           = in_valid && in_ready_r;
		pop            = out_valid_r && out_ready;
		out_valid_nxt  = out_valid_r;
		out_data_nxt   = out_data_r;
		skid_valid_nxt = skid_valid_r;
		skid_data_nxt  = skid_data_r;
		if (!out_valid_r || pop) begin
			if (skid_valid_r) begin
				out_data_nxt   = skid_data_r;
				out_valid_nxt  = 1'b1;
				skid_valid_nxt = 1'b0;
			end else begin
				out_data_nxt  = push ? in_data : out_data_r;
				out_valid_nxt = push;
			end
		end else if (push) begin
			skid_data_nxt  = in_data;
			skid_valid_nxt = 1'b1;
		end
	end

	// Ready comes from a flop so the filling side never sees a comb path
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			out_valid_r  <= 1'b0;
			out_data_r   <= '0;
			skid_valid_r <= 1'b0;
			skid_data_r  <= '0;
			in_ready_r   <= 1'b1;
		end else begin
			out_valid_r  <= out_valid_nxt;
			out_data_r   <= out_data_nxt;
			skid_valid_r <= skid_valid_nxt;
			skid_data_r  <= skid_data_nxt;
			in_ready_r   <= !skid_valid_nxt;
		end
	end

endmodule : cip_skid2

`default_nettype wire

// >>> hw/cip_packetizer.sv
/*
 * Camera isochronous packetizer: takes raster pixels, serializes them into
 * bytes per the selected format and cuts packets of the documented payload,
 * flagging the first packet of each frame with the header sync bit.
 * Assumes pixels arrive in raster order and configuration is steady in frame.
 */
// Summary of operation
// - First packet carrying a new frame has header sync set to one.
// - Pixels go in raster order, pixel 0 upward, row 0 upward.
// - 320x240 YUV packets carry 40 to 1280 bytes, 1.875 to 60 fps.
// - 640x480 mono 8 packets carry 80 to 2560 bytes, 1.875 to 60 fps.
// - 640x480 mono 16 packets carry 160 to 2560 bytes, 1.875 to 30 fps.
// - 800x600 mono 8 packets carry 500 to 4000 bytes, 7.5 to 60 fps.
// - 1024x768 mono 8 packets carry 384 to 3072 bytes, 3.75 to 30 fps.
// - 800x600 mono 16 packets carry 500 to 4000 bytes, 3.75 to 30 fps.
// - 1024x768 mono 16 packets carry 768 to 3072 bytes, 3.75 to 15 fps.
// - 1280x960 mono 8 packets carry 320 to 2560 bytes, 1.875 to 15 fps.
// - 1280x960 mono 16 packets carry 640 to 2560 bytes, 1.875 to 7.5 fps.
// - Mono 16 sends low byte then high byte; ten bits are effective.
// - YUV sends U, Y, V, Y per pair; chroma from the even pixel.
`timescale 1ns/1ps
`default_nettype none
`include "cip_consts.svh"

module cip_packetizer (
	input  wire logic        ref_clk,
	input  wire logic        resetn,
	input  wire logic [1:0]  cfg_format,
	input  wire logic [2:0]  cfg_mode,
	input  wire logic [2:0]  cfg_rate,
	input  wire logic        pix_valid,
	output var  logic        pix_ready_r,
	input  wire logic [15:0] pix_y,
	input  wire logic [7:0]  pix_u,
	input  wire logic [7:0]  pix_v,
	output var  logic        cfg_err_r,
	output var  logic        pkt_valid_r,
	input  wire logic        pkt_ready,
	output var  logic [7:0]  pkt_data_r,
	output var  logic        pkt_sop_r,
	output var  logic        pkt_eop_r,
	output var  logic        pkt_sync_r
);

	////////////////////////////////////////////////////////////////////
	// Format decode: known pair, allowed rate window, payload size
	function automatic cip_pkg::cip_fmt_t cip_decode(
		input logic [1:0] f,
		input logic [2:0] m,
		input logic [2:0] r
	);
		cip_pkg::cip_fmt_t d;
		logic [12:0]       base;
		logic [2:0]        rlo;
		logic [2:0]        rhi;
		logic              known;
		d      = '0;
		known  = 1'b1;
		{d.pix, d.width, d.height, base, rlo, rhi} =
			{cip_pkg::CIP_PIX_M8, `CIP_W320, `CIP_H240, 13'h000, 3'h0, 3'h0};
		unique case ({f, m})
			`CIP_F0M1: {d.pix, d.width, d.height, base, rlo, rhi} = {cip_pkg::CIP_PIX_YUV,
				`CIP_W320, `CIP_H240, `CIP_B_F0M1, `CIP_R1P875, `CIP_R60};
			`CIP_F0M5: {d.pix, d.width, d.height, base, rlo, rhi} = {cip_pkg::CIP_PIX_M8,
				`CIP_W640, `CIP_H480, `CIP_B_F0M5, `CIP_R1P875, `CIP_R60};
			`CIP_F0M6: {d.pix, d.width, d.height, base, rlo, rhi} = {cip_pkg::CIP_PIX_M16,
				`CIP_W640, `CIP_H480, `CIP_B_F0M6, `CIP_R1P875, `CIP_R30};
			`CIP_F1M2: {d.pix, d.width, d.height, base, rlo, rhi} = {cip_pkg::CIP_PIX_M8,
				`CIP_W800, `CIP_H600, `CIP_B_F1M2, `CIP_R7P5, `CIP_R60};
			`CIP_F1M5: {d.pix, d.width, d.height, base, rlo, rhi} = {cip_pkg::CIP_PIX_M8,
				`CIP_W1024, `CIP_H768, `CIP_B_F1M5, `CIP_R3P75, `CIP_R30};
			`CIP_F1M6: {d.pix, d.width, d.height, base, rlo, rhi} = {cip_pkg::CIP_PIX_M16,
				`CIP_W800, `CIP_H600, `CIP_B_F1M6, `CIP_R3P75, `CIP_R30};
			`CIP_F1M7: {d.pix, d.width, d.height, base, rlo, rhi} = {cip_pkg::CIP_PIX_M16,
				`CIP_W1024, `CIP_H768, `CIP_B_F1M7, `CIP_R3P75, `CIP_R15};
			`CIP_F2M2: {d.pix, d.width, d.height, base, rlo, rhi} = {cip_pkg::CIP_PIX_M8,
				`CIP_W1280, `CIP_H960, `CIP_B_F2M2, `CIP_R1P875, `CIP_R15};
			`CIP_F2M6: {d.pix, d.width, d.height, base, rlo, rhi} = {cip_pkg::CIP_PIX_M16,
				`CIP_W1280, `CIP_H960, `CIP_B_F2M6, `CIP_R1P875, `CIP_R7P5};
			default:   known = 1'b0;
		endcase
		d.valid = known && (r >= rlo) && (r <= rhi);
		d.size  = base << r;
		return d;
	endfunction : cip_decode

	////////////////////////////////////////////////////////////////////
	// State
	cip_pkg::cip_state_t st_r;
	cip_pkg::cip_state_t st_nxt;
	cip_pkg::cip_fmt_t   fmt_r;
	cip_pkg::cip_fmt_t   fmt_nxt;
	cip_pkg::cip_fmt_t   fmt_new;
	cip_pkg::cip_fmt_t   fmt_use;
	logic [10:0]         col_r;
	logic [10:0]         col_nxt;
	logic [10:0]         row_r;
	logic [10:0]         row_nxt;
	logic [15:0]         hold_y_r;
	logic [15:0]         hold_y_nxt;
	logic [7:0]          hold_c_r;
	logic [7:0]          hold_c_nxt;
	logic [7:0]          vsave_r;
	logic [7:0]          vsave_nxt;
	logic                hold_odd_r;
	logic                hold_odd_nxt;
	logic                pix_last_r;
	logic                pix_last_nxt;
	logic                frame_pend_r;
	logic                frame_pend_nxt;
	logic                sync_cur_r;
	logic                sync_cur_nxt;
	logic [12:0]         pkt_cnt_r;
	logic [12:0]         pkt_cnt_nxt;
	logic                cfg_err_nxt;
	logic                pix_ready_nxt;
	logic                accept;
	logic                first_pix;
	logic                row_end;
	logic                emit_go;
	logic                last_byte;
	logic                wr;
	logic [7:0]          wdata;
	logic                wsop;
	logic                weop;
	logic                wsync;
	logic                buf_in_ready;

	////////////////////////////////////////////////////////////////////
	// Pixel intake, raster position, byte selection and packet cutting
	always_comb begin
		st_nxt         = st_r;
		fmt_nxt        = fmt_r;
		col_nxt        = col_r;
		row_nxt        = row_r;
		hold_y_nxt     = hold_y_r;
		hold_c_nxt     = hold_c_r;
		vsave_nxt      = vsave_r;
		hold_odd_nxt   = hold_odd_r;
		pix_last_nxt   = pix_last_r;
		frame_pend_nxt = frame_pend_r;
		sync_cur_nxt   = sync_cur_r;
		pkt_cnt_nxt    = pkt_cnt_r;
		cfg_err_nxt    = cfg_err_r;
		accept         = pix_valid && pix_ready_r;
		first_pix      = (col_r == 11'h000) && (row_r == 11'h000);
		fmt_new        = cip_decode(cfg_format, cfg_mode, cfg_rate);
		// Selection is sampled only at a frame start, never mid-frame
		fmt_use        = first_pix ? fmt_new : fmt_r;
		row_end        = (col_r == fmt_use.width - 11'h001);
		emit_go        = (st_r != cip_pkg::CIP_S_IDLE) && (buf_in_ready || !fmt_r.valid);
		wr             = emit_go && fmt_r.valid;
		last_byte      = (st_r == cip_pkg::CIP_S_HI) || (fmt_r.pix == cip_pkg::CIP_PIX_M8);
		wdata          = hold_y_r[7:0];
		unique case (st_r)
			cip_pkg::CIP_S_IDLE: begin
				if (accept) begin
					fmt_nxt      = fmt_use;
					hold_y_nxt   = pix_y;
					hold_odd_nxt = col_r[0];
					// Odd pixel reuses the V of its even partner
					hold_c_nxt   = col_r[0] ? vsave_r : pix_u;
					vsave_nxt    = col_r[0] ? vsave_r : pix_v;
					pix_last_nxt = row_end && (row_r == fmt_use.height - 11'h001);
					col_nxt      = row_end ? 11'h000 : col_r + 11'h001;
					if (row_end) begin
						row_nxt = pix_last_nxt ? 11'h000 : row_r + 11'h001;
					end
					if (first_pix) begin
						cfg_err_nxt = !fmt_new.valid;
					end
					st_nxt = cip_pkg::CIP_S_LO;
				end
			end
			cip_pkg::CIP_S_LO: begin
				if (fmt_r.pix == cip_pkg::CIP_PIX_YUV) begin
					wdata = hold_c_r;
				end
				if (emit_go) begin
					st_nxt = last_byte ? cip_pkg::CIP_S_IDLE : cip_pkg::CIP_S_HI;
				end
			end
			cip_pkg::CIP_S_HI: begin
				if (fmt_r.pix == cip_pkg::CIP_PIX_M16) begin
					wdata = hold_y_r[15:8];
				end
				if (emit_go) begin
					st_nxt = cip_pkg::CIP_S_IDLE;
				end
			end
		endcase
		wsop  = (pkt_cnt_r == 13'h000);
		weop  = (pkt_cnt_r == fmt_r.size - 13'h001) || (last_byte && pix_last_r);
		wsync = wsop ? frame_pend_r : sync_cur_r;
		if (wr) begin
			pkt_cnt_nxt = weop ? 13'h000 : pkt_cnt_r + 13'h001;
			if (wsop) begin
				sync_cur_nxt   = frame_pend_r;
				frame_pend_nxt = 1'b0;
			end
		end
		// A frame start arms sync; set beats a same-cycle clear
		if (accept && first_pix && fmt_new.valid) begin
			frame_pend_nxt = 1'b1;
		end
		// A dropped invalid frame leaves no partial packet behind
		if (emit_go && !fmt_r.valid) begin
			pkt_cnt_nxt = 13'h000;
		end
		pix_ready_nxt = (st_nxt == cip_pkg::CIP_S_IDLE);
	end

	// Register bank of the serializer
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			st_r         <= cip_pkg::CIP_S_IDLE;
			fmt_r        <= '0;
			col_r        <= 11'h000;
			row_r        <= 11'h000;
			hold_y_r     <= 16'h0000;
			hold_c_r     <= 8'h00;
			vsave_r      <= 8'h00;
			hold_odd_r   <= 1'b0;
			pix_last_r   <= 1'b0;
			frame_pend_r <= 1'b0;
			sync_cur_r   <= 1'b0;
			pkt_cnt_r    <= 13'h000;
			cfg_err_r    <= 1'b0;
			pix_ready_r  <= 1'b1;
		end else begin
			st_r         <= st_nxt;
			fmt_r        <= fmt_nxt;
			col_r        <= col_nxt;
			row_r        <= row_nxt;
			hold_y_r     <= hold_y_nxt;
			hold_c_r     <= hold_c_nxt;
			vsave_r      <= vsave_nxt;
			hold_odd_r   <= hold_odd_nxt;
			pix_last_r   <= pix_last_nxt;
			frame_pend_r <= frame_pend_nxt;
			sync_cur_r   <= sync_cur_nxt;
			pkt_cnt_r    <= pkt_cnt_nxt;
			cfg_err_r    <= cfg_err_nxt;
			pix_ready_r  <= pix_ready_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Output buffer absorbs a receiver stall without losing a byte
	cip_skid2 #(
		.WIDTH(`CIP_BW)
	) u_buf (
		.ref_clk    (ref_clk),
		.resetn     (resetn),
		.in_valid   (wr),
		.in_ready_r (buf_in_ready),
		.in_data    ({wsync, wsop, weop, wdata}),
		.out_valid_r(pkt_valid_r),
		.out_ready  (pkt_ready),
		.out_data_r ({pkt_sync_r, pkt_sop_r, pkt_eop_r, pkt_data_r})
	);

	////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	// Judged from the raster position, not from the sync flag it guards
	property p_sync_first;
		wr && st_r == cip_pkg::CIP_S_LO && col_r == 11'h001 && row_r == 11'h000
			|-> wsop && wsync;
	endproperty
	a_sync_first: assert property (p_sync_first) else $error("frame start lacks sync");

	property p_sync_later;
		wr && wsop && !(st_r == cip_pkg::CIP_S_LO && col_r == 11'h001 && row_r == 11'h000)
			|-> !wsync;
	endproperty
	a_sync_later: assert property (p_sync_later) else $error("sync on later packet");

	property p_raster;
		accept && !row_end |=> (col_r == $past(col_r) + 11'h001) && (row_r == $past(row_r));
	endproperty
	a_raster: assert property (p_raster) else $error("pixel order broken");

	property p_pkt_len;
		wr && weop && !(last_byte && pix_last_r) |-> pkt_cnt_r == fmt_r.size - 13'h001;
	endproperty
	a_pkt_len: assert property (p_pkt_len) else $error("packet cut at wrong length");

	property p_yuv_size;
		fmt_r.valid && fmt_r.pix == cip_pkg::CIP_PIX_YUV |->
			fmt_r.size inside {13'h028, 13'h050, 13'h0a0, 13'h140, 13'h280, 13'h500};
	endproperty
	a_yuv_size: assert property (p_yuv_size) else $error("bad YUV payload");

	property p_m8_800_size;
		fmt_r.valid && fmt_r.pix == cip_pkg::CIP_PIX_M8 && fmt_r.width == `CIP_W800 |->
			fmt_r.size inside {13'h1f4, 13'h3e8, 13'h7d0, 13'hfa0};
	endproperty
	a_m8_800_size: assert property (p_m8_800_size) else $error("bad 800 mono8 payload");

	property p_m16_1024_size;
		fmt_r.valid && fmt_r.pix == cip_pkg::CIP_PIX_M16 && fmt_r.width == `CIP_W1024 |->
			fmt_r.size inside {13'h300, 13'h600, 13'hc00};
	endproperty
	a_m16_1024_size: assert property (p_m16_1024_size) else $error("bad 1024 mono16 size");

	property p_m16_order;
		wr && fmt_r.pix == cip_pkg::CIP_PIX_M16 |->
			wdata == ((st_r == cip_pkg::CIP_S_LO) ? hold_y_r[7:0] : hold_y_r[15:8]);
	endproperty
	a_m16_order: assert property (p_m16_order) else $error("mono16 byte order wrong");

	property p_yuv_chroma;
		wr && st_r == cip_pkg::CIP_S_LO && fmt_r.pix == cip_pkg::CIP_PIX_YUV && hold_odd_r
			|-> wdata == vsave_r;
	endproperty
	a_yuv_chroma: assert property (p_yuv_chroma) else $error("V not from even pixel");

	c_frame_sync: cover property (wr && wsop && wsync);
	c_stall: cover property (pkt_valid_r && !pkt_ready ##1 !buf_in_ready);
	c_frame_end: cover property (wr && weop && pix_last_r);

endmodule : cip_packetizer

`default_nettype wire

// >>> bench/cip_host_model.sv
/*
 * Host receiver model: takes packet bytes and keeps them in a queue.
 * Assumes the packetizer's clock; the bench reads and clears rx_q.
 */
`timescale 1ns/1ps
`default_nettype none

module cip_host_model (
	input  wire logic       ref_clk,
	input  wire logic       resetn,
	input  wire logic       stall_en,
	input  wire logic       pkt_valid_r,
	input  wire logic [7:0] pkt_data_r,
	input  wire logic       pkt_sop_r,
	input  wire logic       pkt_eop_r,
	input  wire logic       pkt_sync_r,
	output var  logic       pkt_ready
);
	logic [10:0] rx_q[$];
	logic [1:0]  slot_r;

	initial begin
		pkt_ready = 1'b0;
		slot_r = 2'h0;
	end

	// Byte taken at the edge; ready moves just after it
	always @(posedge ref_clk) begin
		if (resetn && pkt_valid_r && pkt_ready)
			rx_q.push_back({pkt_sync_r, pkt_sop_r, pkt_eop_r, pkt_data_r});
		#1;
		slot_r = slot_r + 2'h1;
		// Stalling host accepts one cycle in four, so the buffer fills
		pkt_ready = resetn && !(stall_en && slot_r != 2'h0);
	end
endmodule : cip_host_model

`default_nettype wire

// >>> bench/tb.sv
/*
 * Self-checking bench of the camera packetizer: pixel feeder and scenarios.
 * Assumes the design under hw/ and the host model in cip_host_model.sv.
 */
`timescale 1ns/1ps
`default_nettype none

module tb;
	localparam int CEIL = 60000;
	logic        ref_clk;
	logic        resetn;
	logic [1:0]  cfg_format;
	logic [2:0]  cfg_mode;
	logic [2:0]  cfg_rate;
	logic        pix_valid;
	logic        pix_ready_r;
	logic [15:0] pix_y;
	logic [7:0]  pix_u;
	logic [7:0]  pix_v;
	logic        cfg_err_r;
	logic        pkt_valid_r;
	logic        pkt_ready;
	logic [7:0]  pkt_data_r;
	logic        pkt_sop_r;
	logic        pkt_eop_r;
	logic        pkt_sync_r;
	logic        feed_en;
	logic        stall_en;
	logic        took;
	int          fails;
	int          checked;
	int          cycles;
	int          pix_idx;
	int          pix_lim;

	cip_packetizer i_cip_packetizer (.ref_clk(ref_clk), .resetn(resetn),
		.cfg_format(cfg_format), .cfg_mode(cfg_mode), .cfg_rate(cfg_rate),
		.pix_valid(pix_valid), .pix_ready_r(pix_ready_r), .pix_y(pix_y),
		.pix_u(pix_u), .pix_v(pix_v), .cfg_err_r(cfg_err_r),
		.pkt_valid_r(pkt_valid_r), .pkt_ready(pkt_ready), .pkt_data_r(pkt_data_r),
		.pkt_sop_r(pkt_sop_r), .pkt_eop_r(pkt_eop_r), .pkt_sync_r(pkt_sync_r));

	cip_host_model i_cip_host_model (.ref_clk(ref_clk), .resetn(resetn),
		.stall_en(stall_en), .pkt_valid_r(pkt_valid_r), .pkt_data_r(pkt_data_r),
		.pkt_sop_r(pkt_sop_r), .pkt_eop_r(pkt_eop_r), .pkt_sync_r(pkt_sync_r),
		.pkt_ready(pkt_ready));

	////////////////////////////////////////////////////////////////
	// Pixel pattern; chroma differs per pixel so a wrong pick shows
	function automatic logic [15:0] y_of(input int k);
		return {8'(k) ^ 8'h5a, 8'(k) + 8'h11};
	endfunction : y_of

	function automatic logic [7:0] u_of(input int k);
		return 8'(k) + 8'h30;
	endfunction : u_of

	function automatic logic [7:0] v_of(input int k);
		return 8'(k) ^ 8'hc3;
	endfunction : v_of

	// Byte i of the stream for the given pixel coding
	function automatic logic [7:0] exp_byte(input cip_pkg::cip_pix_t k, input int i);
		logic [15:0] y;
		int          p;
		p = (k == cip_pkg::CIP_PIX_M8) ? i : i / 2;
		y = y_of(p);
		if (k == cip_pkg::CIP_PIX_M8)
			return y[7:0];
		if (i % 2 == 1)
			return (k == cip_pkg::CIP_PIX_M16) ? y[15:8] : y[7:0];
		if (k == cip_pkg::CIP_PIX_M16)
			return y[7:0];
		return (p % 2 == 0) ? u_of(p) : v_of(p - 1);
	endfunction : exp_byte

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("wrong value %s: expected %0h, seen %0h", what, exp, got);
		end
	endtask : chk

	task automatic final_report;
		if (fails == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : final_report

	////////////////////////////////////////////////////////////////
	// Clock, hang guard and pixel feeder
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == CEIL) begin
			fails++;
			final_report();
		end
	end

	// Pixel held until taken, then the next one shortly after the edge
	always @(posedge ref_clk) begin
		took = pix_valid && pix_ready_r;
		#1;
		if (took)
			pix_idx++;
		pix_valid = feed_en && (pix_idx < pix_lim);
		pix_y = y_of(pix_idx);
		pix_u = u_of(pix_idx);
		pix_v = v_of(pix_idx);
	end

	////////////////////////////////////////////////////////////////
	// Reset restarts the frame, so every case begins at row 0 col 0
	task automatic apply_reset(input logic [1:0] f, input logic [2:0] m,
			input logic [2:0] r, input logic s);
		@(posedge ref_clk);
		#1;
		feed_en = 1'b0;
		pix_lim = 0;
		resetn = 1'b0;
		cfg_format = f;
		cfg_mode = m;
		cfg_rate = r;
		stall_en = s;
		repeat (10) @(posedge ref_clk);
		#1;
		chk("ready in reset", 32'h1, 32'(pix_ready_r));
		chk("valid in reset", 32'h0, 32'(pkt_valid_r));
		i_cip_host_model.rx_q.delete();
		pix_idx = 0;
		resetn = 1'b1;
	endtask : apply_reset

	// Feeds npk packets' worth of pixels and judges every byte received
	task automatic run_case(input logic [1:0] f, input logic [2:0] m, input logic [2:0] r,
			input cip_pkg::cip_pix_t k, input int size, input int npk, input logic s);
		logic [10:0] w;
		int          nb;
		int          n;
		nb = size * npk;
		apply_reset(f, m, r, s);
		pix_lim = (k == cip_pkg::CIP_PIX_M8) ? nb : nb / 2;
		feed_en = 1'b1;
		for (n = 0; n < 40000 && i_cip_host_model.rx_q.size() < nb; n++)
			@(posedge ref_clk);
		repeat (20) @(posedge ref_clk);
		chk("config error", 32'h0, 32'(cfg_err_r));
		chk("byte count", 32'(nb), 32'(i_cip_host_model.rx_q.size()));
		for (n = 0; n < nb && n < i_cip_host_model.rx_q.size(); n++) begin
			w = i_cip_host_model.rx_q[n];
			chk("data", 32'(exp_byte(k, n)), 32'(w[7:0]));
			chk("sop eop", 32'({n % size == 0, n % size == size - 1}), 32'(w[9:8]));
			chk("sync", 32'(n < size), 32'(w[10]));
		end
	endtask : run_case

	// Rate outside the mode's window, or unknown format/mode pair: whole frame dropped
	task automatic bad_case(input logic [1:0] f, input logic [2:0] m, input logic [2:0] r);
		apply_reset(f, m, r, 1'b0);
		pix_lim = 8;
		feed_en = 1'b1;
		repeat (60) @(posedge ref_clk);
		chk("config error", 32'h1, 32'(cfg_err_r));
		chk("dropped bytes", 32'h0, 32'(i_cip_host_model.rx_q.size()));
	endtask : bad_case

	////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic scn_sizes;
		run_case(2'h0, 3'h1, 3'h0, cip_pkg::CIP_PIX_YUV, 40, 2, 1'b0);
		run_case(2'h0, 3'h1, 3'h5, cip_pkg::CIP_PIX_YUV, 1280, 2, 1'b0);
		run_case(2'h0, 3'h5, 3'h0, cip_pkg::CIP_PIX_M8, 80, 2, 1'b0);
		run_case(2'h0, 3'h6, 3'h4, cip_pkg::CIP_PIX_M16, 2560, 1, 1'b0);
		run_case(2'h1, 3'h2, 3'h2, cip_pkg::CIP_PIX_M8, 500, 2, 1'b0);
		run_case(2'h1, 3'h2, 3'h5, cip_pkg::CIP_PIX_M8, 4000, 1, 1'b0);
		run_case(2'h1, 3'h5, 3'h1, cip_pkg::CIP_PIX_M8, 384, 2, 1'b0);
		run_case(2'h1, 3'h6, 3'h1, cip_pkg::CIP_PIX_M16, 500, 2, 1'b0);
		run_case(2'h1, 3'h7, 3'h3, cip_pkg::CIP_PIX_M16, 3072, 1, 1'b0);
		run_case(2'h2, 3'h2, 3'h0, cip_pkg::CIP_PIX_M8, 320, 2, 1'b0);
		run_case(2'h2, 3'h6, 3'h0, cip_pkg::CIP_PIX_M16, 640, 2, 1'b0);
	endtask : scn_sizes

	// Slow host: buffer fills, pixel intake must stall without loss
	task automatic scn_mono16_stall;
		run_case(2'h0, 3'h6, 3'h0, cip_pkg::CIP_PIX_M16, 160, 2, 1'b1);
	endtask : scn_mono16_stall

	// Two packets of one row each: crosses into row 1
	task automatic scn_yuv_rows;
		run_case(2'h0, 3'h1, 3'h4, cip_pkg::CIP_PIX_YUV, 640, 2, 1'b0);
	endtask : scn_yuv_rows

	task automatic scn_bad_cfg;
		bad_case(2'h0, 3'h6, 3'h5);
		bad_case(2'h1, 3'h2, 3'h1);
		bad_case(2'h1, 3'h7, 3'h4);
		bad_case(2'h3, 3'h0, 3'h0);
	endtask : scn_bad_cfg

	initial begin
		resetn = 1'b0;
		cfg_format = 2'h0;
		cfg_mode = 3'h0;
		cfg_rate = 3'h0;
		pix_valid = 1'b0;
		pix_y = 16'h0000;
		pix_u = 8'h00;
		pix_v = 8'h00;
		feed_en = 1'b0;
		stall_en = 1'b0;
		fails = 0;
		checked = 0;
		cycles = 0;
		pix_idx = 0;
		pix_lim = 0;
		scn_sizes();
		scn_mono16_stall();
		scn_yuv_rows();
		scn_bad_cfg();
		final_report();
	end
endmodule : tb

`default_nettype wire
